// file: rtl/bit_sync.sv
// Two-flop synchroniser, one stage pair per bit.
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta;
            // The first stage feeds only the second stage.
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta <= RESET_VALUE[i];
                    q[i] <= RESET_VALUE[i];
                end else begin
                    meta <= d[i];
                    q[i] <= meta;
                end
            end
        end
    endgenerate

endmodule

// file: rtl/read_port_mem.sv
// Array storage with a preload write port and a registered read port on another clock.
`timescale 1ns/1ps
module read_port_mem #(
    parameter int ADDR_W = 17,
    parameter int DATA_W = 8
) (
    // Preload side
    input wire logic wrClk,
    input wire logic wrEn,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [DATA_W-1:0] wrData,
    // Read side
    input wire logic rdClk,
    input wire logic rdEn,
    input wire logic [ADDR_W-1:0] rdAddr,
    output logic [DATA_W-1:0] rdData
);

    logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];

    // Preload writes.
    always_ff @(posedge wrClk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // Registered read, so the output shifter always sees a settled byte.
    always_ff @(posedge rdClk) begin
        if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

// file: rtl/serial_flash_front.sv
// Serial flash command front end: write latch, status register and read instructions.
// Summary of operation
// - Write-enable code sets the write latch when its frame ends cleanly.
// - Volatile-enable right before a status write makes it volatile; latch untouched.
// - Write-disable code clears the write latch.
// - Write-disable also cancels a pending volatile enable.
// - Write latch is clear after power-up and after a non-volatile status write completes.
// - Read-status returns the 8-bit status MSB first on falling edges.
// - Read-status works while busy and repeats the byte until select rises.
// - Status write with its data byte is taken only when the latch is set or a volatile enable came right before.
// - Status write changes only lock, top/bottom and both guard bits.
// - Status write must end exactly after eight data bits, else abandoned.
// - Non-volatile status write runs a timed busy cycle, then clears the latch.
// - With lock set, status writes are refused while write-protect is low.
// - Volatile status write lands within the refresh time; busy stays zero.
// - The two guard bits alone choose all, part or none of the array.
// - Normal read takes code and 24-bit address, then streams data MSB first.
// - Read address advances per byte and wraps across the whole array.
// - Normal read while busy is ignored and leaves the cycle alone.
// - Fast read waits eight dummy clocks, ignoring the input line.
// - Dual-output read is fast read with data two bits per clock.
// - Dual-address read takes address and mode byte two bits per clock.
// - Line zero carries even address and mode bits, line one the odd bits.
// - Dual data puts bits 6,4,2,0 on line zero and 7,5,3,1 on line one.
// - Each frame starts at select falling, first byte is the command, MSB first.
// - While busy, every command except read-status is ignored.
`timescale 1ns/1ps
module serial_flash_front #(
    parameter int ADDR_W = serial_flash_pkg::MEM_ADDR_BITS,
    parameter int STATUS_WRITE_CYCLES = serial_flash_pkg::STATUS_WRITE_CYCLES_DEF
) (
    // Core clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Serial link
    input wire logic sclk,
    input wire logic csN,
    input wire logic dualLineZeroIn,
    output logic dualLineZeroOut,
    output logic dualLineZeroOe,
    input wire logic dualLineOneIn,
    output logic dualLineOneOut,
    output logic dualLineOneOe,
    // Write protect pin
    input wire logic wpN,
    // Array preload
    input wire logic memLoadEn,
    input wire logic [ADDR_W-1:0] memLoadAddr,
    input wire logic [7:0] memLoadData,
    // Observation
    output logic [7:0] statusView,
    output serial_flash_pkg::guard_mode_t guardMode
);
    import serial_flash_pkg::*;

    localparam int VolLimit = VOLATILE_REFRESH_CYCLES;

    // Link-domain state; select high holds the sequencer and output registers in reset, so each frame starts clean.
    logic frameRst;
    link_state_t state;
    logic [4:0] bitCnt;
    logic [7:0] cmd;
    logic [31:0] addrShift;
    logic [23:0] curAddr;
    logic [2:0] beat;
    logic dualIn;
    logic dualOut;
    logic needDummy;
    logic statMode;
    logic [7:0] statusLink;
    logic busyLink;
    frame_result_t pend;
    logic [7:0] outShift;
    logic [7:0] memData;
    logic [7:0] nextCmd;
    logic [31:0] nextShift;
    logic [23:0] assembled;
    logic addrDone;
    logic [2:0] lastBeat;
    logic readFire;
    logic [23:0] readAddr;
    logic [7:0] byteNow;

    // Core-domain state.
    logic csSync;
    logic wpSync;
    logic csPrev;
    logic csRise;
    logic evt;
    logic wsrGo;
    logic wsrAllowed;
    logic write_latch_flag;
    logic volArm;
    logic busy;
    logic busyDone;
    logic [31:0] timer;
    logic [7:0] activeBits;
    logic [7:0] heldBits;
    logic [7:0] statusValue;

    assign frameRst = rst | csN;
    assign busyLink = statusLink[ST_BUSY];

    // Next-value terms for the link sequencer and the array read port.
    always_comb begin
        nextCmd = {cmd[6:0], dualLineZeroIn};
        // Line one holds the odd (higher) bit of each pair.
        nextShift = dualIn ? {addrShift[29:0], dualLineOneIn, dualLineZeroIn}
                           : {addrShift[30:0], dualLineZeroIn};
        assembled = dualIn ? nextShift[31:8] : nextShift[23:0];
        addrDone = (state == LS_ADDR)
            && (bitCnt == (dualIn ? ADDR_LAST_DUAL : ADDR_LAST_SINGLE));
        lastBeat = dualOut ? BEAT_LAST_DUAL : BEAT_LAST_SINGLE;
        readFire = 1'b0;
        readAddr = curAddr + 24'h000001;
        if (addrDone && !needDummy) begin
            readFire = 1'b1;
            readAddr = assembled;
        end else if (state == LS_DUMMY && bitCnt == BYTE_LAST) begin
            readFire = 1'b1;
            readAddr = curAddr;
        end else if (state == LS_OUT && beat == lastBeat && !statMode) begin
            readFire = 1'b1;
        end
    end

    // Command, address and dummy sequencing on rising link clock edges.
    always_ff @(posedge sclk or posedge frameRst) begin
        if (frameRst) begin
            state <= LS_CMD;
            bitCnt <= 5'h00;
            cmd <= 8'h00;
            addrShift <= 32'h00000000;
            curAddr <= 24'h000000;
            beat <= 3'h0;
            dualIn <= 1'b0;
            dualOut <= 1'b0;
            needDummy <= 1'b0;
            statMode <= 1'b0;
        end else begin
            case (state)
                LS_CMD: begin
                    cmd <= nextCmd;
                    bitCnt <= bitCnt + 5'h01;
                    if (bitCnt == BYTE_LAST) begin
                        bitCnt <= 5'h00;
                        if (busyLink && nextCmd != CMD_READ_STATUS) begin
                            state <= LS_IGNORE;
                        end else begin
                            case (nextCmd)
                                CMD_READ_STATUS: begin
                                    state <= LS_OUT;
                                    statMode <= 1'b1;
                                    beat <= 3'h0;
                                end
                                CMD_READ, CMD_FAST_READ, CMD_DUAL_OUT_READ: begin
                                    state <= LS_ADDR;
                                    needDummy <= (nextCmd != CMD_READ);
                                    dualOut <= (nextCmd == CMD_DUAL_OUT_READ);
                                end
                                CMD_DUAL_IO_READ: begin
                                    state <= LS_ADDR;
                                    dualIn <= 1'b1;
                                    dualOut <= 1'b1;
                                end
                                CMD_WRITE_STATUS: begin
                                    state <= LS_WDATA;
                                end
                                CMD_WRITE_ENABLE, CMD_WRITE_DISABLE, CMD_VOLATILE_ENABLE: begin
                                    state <= LS_DONE;
                                end
                                default: begin
                                    state <= LS_IGNORE;
                                end
                            endcase
                        end
                    end
                end
                LS_ADDR: begin
                    addrShift <= nextShift;
                    bitCnt <= bitCnt + 5'h01;
                    if (addrDone) begin
                        bitCnt <= 5'h00;
                        curAddr <= assembled;
                        beat <= 3'h0;
                        state <= needDummy ? LS_DUMMY : LS_OUT;
                    end
                end
                LS_DUMMY: begin
                    // The input line is not looked at while the dummy clocks pass.
                    bitCnt <= bitCnt + 5'h01;
                    if (bitCnt == BYTE_LAST) begin
                        state <= LS_OUT;
                        beat <= 3'h0;
                    end
                end
                LS_OUT: begin
                    beat <= (beat == lastBeat) ? 3'h0 : beat + 3'h1;
                    if (beat == lastBeat && !statMode) begin
                        curAddr <= curAddr + 24'h000001;
                    end
                end
                LS_WDATA: begin
                    addrShift <= nextShift;
                    bitCnt <= bitCnt + 5'h01;
                    if (bitCnt == BYTE_LAST) begin
                        state <= LS_DONE;
                    end
                end
                LS_DONE: begin
                    state <= LS_IGNORE;
                end
                LS_IGNORE: begin
                    state <= LS_IGNORE;
                end
                default: begin
                    state <= LS_IGNORE;
                end
            endcase
        end
    end

    // Frame result for the core. It is not cleared by select, because the core reads
    // it only after select rises, when the link clock has stopped and it is stable.
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            pend <= '0;
        end else if (state == LS_CMD && bitCnt == BYTE_LAST && !busyLink
                     && (nextCmd == CMD_WRITE_ENABLE || nextCmd == CMD_WRITE_DISABLE
                         || nextCmd == CMD_VOLATILE_ENABLE)) begin
            pend <= '{valid: 1'b1, code: nextCmd, data: 8'h00};
        end else if (state == LS_WDATA && bitCnt == BYTE_LAST) begin
            pend <= '{valid: 1'b1, code: CMD_WRITE_STATUS, data: nextShift[7:0]};
        end else if (state == LS_DONE || (state == LS_CMD && bitCnt == 5'h00)) begin
            pend.valid <= 1'b0;
        end
    end

    // Byte presented to the output shifter at the first beat of each byte.
    always_comb begin
        byteNow = outShift;
        if (beat == 3'h0) begin
            byteNow = statMode ? statusLink : memData;
        end
    end

    // Output drive on falling link clock edges; line one doubles as the single output.
    always_ff @(negedge sclk or posedge frameRst) begin
        if (frameRst) begin
            outShift <= 8'h00;
            dualLineZeroOut <= 1'b0;
            dualLineZeroOe <= 1'b0;
            dualLineOneOut <= 1'b0;
            dualLineOneOe <= 1'b0;
        end else if (state == LS_OUT) begin
            dualLineOneOut <= byteNow[7];
            dualLineOneOe <= 1'b1;
            if (dualOut) begin
                dualLineZeroOut <= byteNow[6];
                dualLineZeroOe <= 1'b1;
                outShift <= {byteNow[5:0], 2'b00};
            end else begin
                dualLineZeroOe <= 1'b0;
                outShift <= {byteNow[6:0], 1'b0};
            end
        end else begin
            dualLineZeroOe <= 1'b0;
            dualLineOneOe <= 1'b0;
        end
    end

    // Array storage, read on the link clock.
    read_port_mem #(
        .ADDR_W(ADDR_W),
        .DATA_W(8)
    ) u_mem (
        .wrClk(clk),
        .wrEn(memLoadEn),
        .wrAddr(memLoadAddr),
        .wrData(memLoadData),
        .rdClk(sclk),
        .rdEn(readFire),
        .rdAddr(readAddr[ADDR_W-1:0]),
        .rdData(memData)
    );

    // Status copy for the link, taken from the registered view so that no gate output
    // is sampled across domains. It lags by two link clocks, well inside one byte.
    bit_sync #(
        .WIDTH(8),
        .RESET_VALUE(ST_RESET)
    ) u_status_sync (
        .clk(sclk),
        .rst(rst),
        .d(statusView),
        .q(statusLink)
    );

    // Select and write-protect pins into the core clock.
    bit_sync #(
        .WIDTH(2),
        .RESET_VALUE(2'h3)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .d({csN, wpN}),
        .q({csSync, wpSync})
    );

    // Frame-end detection and decoding of the finished frame.
    assign csRise = ce & csSync & ~csPrev;
    assign evt = csRise & pend.valid;
    assign wsrAllowed = (write_latch_flag | volArm) & ~(activeBits[ST_LOCK] & ~wpSync);
    assign wsrGo = evt && pend.code == CMD_WRITE_STATUS && wsrAllowed;
    assign busyDone = ce & busy & (timer == 32'h00000001);
    assign statusValue = (activeBits & ST_WRITABLE_MASK)
        | {6'h00, write_latch_flag, busy};

    // Select edge tracker.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            csPrev <= 1'b1;
        end else if (ce) begin
            csPrev <= csSync;
        end
    end

    // Write latch: set, cleared, and cleared again when a timed write completes.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_latch_flag <= 1'b0;
        end else if (busyDone) begin
            write_latch_flag <= 1'b0;
        end else if (evt && pend.code == CMD_WRITE_ENABLE) begin
            write_latch_flag <= 1'b1;
        end else if (evt && pend.code == CMD_WRITE_DISABLE) begin
            write_latch_flag <= 1'b0;
        end
    end

    // Volatile arm lasts only until the next frame ends, whatever that frame was.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            volArm <= 1'b0;
        end else if (csRise) begin
            volArm <= evt && pend.code == CMD_VOLATILE_ENABLE;
        end
    end

    // Self-timed status write cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            timer <= 32'h00000000;
        end else if (ce) begin
            if (busy) begin
                timer <= timer - 32'h00000001;
                if (timer == 32'h00000001) begin
                    busy <= 1'b0;
                end
            end else if (wsrGo && !volArm) begin
                busy <= 1'b1;
                timer <= 32'(STATUS_WRITE_CYCLES);
            end
        end
    end

    // Status bits; there is no true non-volatile store, so power-up gives the reset value.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            activeBits <= ST_RESET;
            heldBits <= ST_RESET;
        end else if (ce) begin
            if (wsrGo && volArm) begin
                activeBits <= pend.data & ST_WRITABLE_MASK;
            end else if (wsrGo) begin
                heldBits <= pend.data & ST_WRITABLE_MASK;
            end else if (busyDone) begin
                activeBits <= heldBits;
            end
        end
    end

    // Registered observation outputs and protection extent.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statusView <= ST_RESET;
            guardMode <= GUARD_NONE;
        end else if (ce) begin
            statusView <= statusValue;
            case ({activeBits[ST_GUARD_HI], activeBits[ST_GUARD_LO]})
                2'h0: guardMode <= GUARD_NONE;
                2'h3: guardMode <= GUARD_ALL;
                default: guardMode <= GUARD_PART;
            endcase
        end
    end

    a_wren_sets: assert property (@(posedge clk) disable iff (rst)
        (evt && pend.code == CMD_WRITE_ENABLE && !busy) |=> write_latch_flag)
        else $error("write latch not set by write enable");
    a_wrdi_clears: assert property (@(posedge clk) disable iff (rst)
        (evt && pend.code == CMD_WRITE_DISABLE && !busy) |=> !write_latch_flag && !volArm)
        else $error("write disable left latch or volatile arm set");
    a_vol_keeps_wel: assert property (@(posedge clk) disable iff (rst)
        (evt && pend.code == CMD_VOLATILE_ENABLE) |=> volArm && write_latch_flag == $past(write_latch_flag))
        else $error("volatile enable disturbed the write latch");
    a_wsr_refused: assert property (@(posedge clk) disable iff (rst)
        (evt && pend.code == CMD_WRITE_STATUS && !write_latch_flag && !volArm)
        |=> !busy && $stable(activeBits) ##1 $stable(activeBits))
        else $error("status write taken without write latch");
    a_lock_rejects: assert property (@(posedge clk) disable iff (rst)
        (evt && activeBits[ST_LOCK] && !wpSync) |=> !busy && $stable(activeBits))
        else $error("locked status write was not refused");
    a_busy_holds: assert property (@(posedge clk) disable iff (rst)
        (wsrGo && !volArm && STATUS_WRITE_CYCLES > 8) |=> busy [*8])
        else $error("busy dropped early in status write cycle");
    a_done_clears: assert property (@(posedge clk) disable iff (rst)
        $fell(busy) |-> !write_latch_flag && activeBits == $past(heldBits))
        else $error("write completion left latch set or bits stale");
    a_vol_refresh: assert property (@(posedge clk) disable iff (rst)
        (wsrGo && volArm) |-> ##[1:VolLimit] (activeBits == (pend.data & ST_WRITABLE_MASK))
        ##0 !busy)
        else $error("volatile status write late or raised busy");
    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        $past(ce) |-> statusView[4] == 1'b0 && statusView[6] == 1'b0
        && statusView[ST_BUSY] == $past(busy) && statusView[ST_WRITE_LATCH] == $past(write_latch_flag))
        else $error("reserved status bits or busy position wrong");
    a_busy_ignores: assert property (@(posedge sclk) disable iff (frameRst)
        (state == LS_CMD && bitCnt == BYTE_LAST && busyLink && nextCmd != CMD_READ_STATUS)
        |=> state == LS_IGNORE)
        else $error("command accepted while busy");

endmodule

// file: rtl/serial_flash_pkg.sv
// Shared constants, types and state encodings for the serial flash command front end.
package serial_flash_pkg;

    // Command codes taken on the serial input line.
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_VOLATILE_ENABLE = 8'h50;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_FAST_READ = 8'h0B;
    localparam logic [7:0] CMD_DUAL_OUT_READ = 8'h3B;
    localparam logic [7:0] CMD_DUAL_IO_READ = 8'hBB;

    // Status register field positions.
    localparam int ST_BUSY = 0;
    localparam int ST_WRITE_LATCH = 1;
    localparam int ST_GUARD_LO = 2;
    localparam int ST_GUARD_HI = 3;
    localparam int ST_TOP_BOTTOM = 5;
    localparam int ST_LOCK = 7;
    localparam logic [7:0] ST_WRITABLE_MASK = 8'hAC;
    localparam logic [7:0] ST_RESET = 8'h00;

    // Field lengths counted in link clocks, stored as last index.
    localparam logic [4:0] BYTE_LAST = 5'h07;
    localparam logic [4:0] ADDR_LAST_SINGLE = 5'h17;
    localparam logic [4:0] ADDR_LAST_DUAL = 5'h0F;
    localparam logic [2:0] BEAT_LAST_SINGLE = 3'h7;
    localparam logic [2:0] BEAT_LAST_DUAL = 3'h3;
    localparam int MEM_ADDR_BITS = 17;

    // Timing: core clock period and self-timed intervals.
    localparam int CLK_PERIOD_NS = 50;
    localparam int STATUS_WRITE_TIME_NS = 10000000;
    localparam int STATUS_WRITE_CYCLES_DEF = (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int VOLATILE_REFRESH_TIME_NS = 1000;
    localparam int VOLATILE_REFRESH_CYCLES = VOLATILE_REFRESH_TIME_NS / CLK_PERIOD_NS;

    // Link-side sequencer states.
    typedef enum logic [2:0] {
        LS_CMD,
        LS_ADDR,
        LS_DUMMY,
        LS_OUT,
        LS_WDATA,
        LS_DONE,
        LS_IGNORE
    } link_state_t;

    // Decoded array protection extent.
    typedef enum logic [1:0] {
        GUARD_NONE,
        GUARD_PART,
        GUARD_ALL
    } guard_mode_t;

    // Result of a completed write-class frame, handed to the core clock.
    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [7:0] data;
    } frame_result_t;

endpackage

// file: tb/host_spi_model.sv
// Host controller model that frames commands on the serial link.
`timescale 1ns/1ps
module host_spi_model (
    // Link pins
    output logic sclk,
    output logic csN,
    output logic zeroIn,
    output logic oneIn,
    input wire logic zeroOut,
    input wire logic zeroOe,
    input wire logic oneOut,
    input wire logic oneOe
);
    logic hostZero;
    logic oneSeen;
    // A released line one reads as the inverse of its last value, so stale data fails.
    assign oneSeen = oneOe ? oneOut : ~oneOut;
    logic [63:0] rx0;
    logic [63:0] rx1;
    // The host lets go of line zero whenever the device drives it.
    assign zeroIn = zeroOe ? zeroOut : hostZero;
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        hostZero = 1'b0;
        oneIn = 1'b1;
    end
    // Clock stands low outside frames; dual entry sends line one first.
    task automatic frame(input logic [63:0] tx, input int n, input bit dual);
        int p;
        p = 0;
        csN <= 1'b0;
        for (int k = 0; k < n; k++) begin
            if (dual && k >= 8) begin
                oneIn <= tx[63-p];
                hostZero <= tx[62-p];
                p += 2;
            end else begin
                hostZero <= tx[63-p];
                p++;
            end
            #80;
            sclk <= 1'b1;
            rx1 <= {rx1[62:0], oneSeen};
            rx0 <= {rx0[62:0], zeroIn};
            #80;
            sclk <= 1'b0;
        end
        #80;
        csN <= 1'b1;
        hostZero <= ~hostZero;
        oneIn <= ~oneIn;
        #400;
    endtask
endmodule

// file: tb/serial_flash_front_tb_top.sv
// Bench for the flash front end: reads, status and write latch.
`timescale 1ns/1ps
module serial_flash_front_tb_top;
    import serial_flash_pkg::*;
    logic clk, rst, ce, wpN, ldEn, sclk, csN, zIn, zOut, zOe, oIn, oOut, oOe;
    logic [3:0] ldAddr;
    logic [7:0] ldData, st;
    guard_mode_t gm;
    int fails = 0;
    int n_tests = 0;
    serial_flash_front #(.ADDR_W(4), .STATUS_WRITE_CYCLES(200)) dut_u (.clk(clk), .rst(rst),
        .ce(ce), .sclk(sclk), .csN(csN), .dualLineZeroIn(zIn), .dualLineZeroOut(zOut),
        .dualLineZeroOe(zOe), .dualLineOneIn(oIn), .dualLineOneOut(oOut),
        .dualLineOneOe(oOe), .wpN(wpN), .memLoadEn(ldEn), .memLoadAddr(ldAddr),
        .memLoadData(ldData), .statusView(st), .guardMode(gm));
    host_spi_model host_u (.sclk(sclk), .csN(csN), .zeroIn(zIn), .oneIn(oIn),
        .zeroOut(zOut), .zeroOe(zOe), .oneOut(oOut), .oneOe(oOe));
    function automatic logic [7:0] mem(int a);
        return 8'h5A ^ 8'(a * 17);
    endfunction
    task automatic chk(string s, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic f(logic [63:0] tx, int n, bit dual = 0);
        host_u.frame(tx, n, dual);
    endtask
    // Dual data: line one holds the odd bits, line zero the even bits.
    task automatic dchk(string s, logic [7:0] d);
        chk(s, {8'h00, d[7], d[5], d[3], d[1], d[6], d[4], d[2], d[0]},
            {8'h00, host_u.rx1[3:0], host_u.rx0[3:0]});
    endtask
    // Two status bytes in one frame, since the byte repeats.
    task automatic rs(string s, logic [7:0] e);
        f({CMD_READ_STATUS, 56'h0}, 24);
        chk(s, {e, e}, host_u.rx1[15:0]);
    endtask
    task automatic vw(logic [7:0] d);
        f({CMD_VOLATILE_ENABLE, 56'h0}, 8);
        f({CMD_WRITE_STATUS, d, 48'h0}, 16);
    endtask
    task automatic end_of_test;
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Watchdog far past the expected run of about 100 us.
    initial begin
        #500000;
        fails++;
        end_of_test;
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        wpN = 1'b1;
        ldEn = 1'b0;
        ldAddr = 4'h0;
        ldData = 8'h00;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            @(posedge clk);
            ldEn <= 1'b1;
            ldAddr <= 4'(a);
            ldData <= mem(a);
        end
        @(posedge clk);
        ldEn <= 1'b0;
        f({CMD_READ, 24'h00000F, 32'h0}, 48);
        chk("read", {mem(15), mem(0)}, host_u.rx1[15:0]);
        f({CMD_FAST_READ, 24'h000002, 32'hFFFFFFFF}, 48);
        chk("fast", {8'h00, mem(2)}, {8'h00, host_u.rx1[7:0]});
        f({CMD_DUAL_OUT_READ, 24'h000001, 32'hFFFFFFFF}, 44);
        dchk("dual out", mem(1));
        f({CMD_DUAL_IO_READ, 24'h000003, 32'h0}, 28, 1);
        dchk("dual io", mem(3));
        rs("idle", 8'h00);
        f({CMD_WRITE_ENABLE, 56'h0}, 8);
        rs("latch", 8'h02);
        f({CMD_WRITE_DISABLE, 56'h0}, 8);
        f({CMD_WRITE_STATUS, 8'hFF, 48'h0}, 16);
        chk("no latch", 16'h0000, {8'h00, st});
        f({CMD_WRITE_ENABLE, 56'h0}, 8);
        f({CMD_WRITE_STATUS, 8'hFF, 48'h0}, 17);
        chk("abandon", 16'h0002, {8'h00, st});
        f({CMD_WRITE_STATUS, 8'hFF, 48'h0}, 16);
        rs("busy", 8'h03);
        // A read decoded while busy must be ignored: line one stays released.
        f({CMD_READ, 24'h000000, 32'h0}, 48);
        chk("busy read", 16'hFFFF, host_u.rx1[15:0]);
        repeat (200) @(posedge clk);
        chk("written", {6'h00, GUARD_ALL, 8'hAC}, {6'h00, gm, st});
        vw(8'h80);
        chk("volatile", {6'h00, GUARD_NONE, 8'h80}, {6'h00, gm, st});
        @(posedge clk);
        wpN <= 1'b0;
        vw(8'h00);
        chk("locked", 16'h0080, {8'h00, st});
        @(posedge clk);
        wpN <= 1'b1;
        f({CMD_VOLATILE_ENABLE, 56'h0}, 8);
        f({CMD_WRITE_DISABLE, 56'h0}, 8);
        f({CMD_WRITE_STATUS, 8'h00, 48'h0}, 16);
        chk("cancel", 16'h0080, {8'h00, st});
        end_of_test;
    end
endmodule
